// ===== rtl/link_pkg.sv
package link_pkg;
    localparam logic [15:0] SCR_SEED = 16'hFFFF;
    localparam logic [31:0] CRC_INIT = 32'h52325032;
    localparam logic [31:0] CRC_POLY = 32'h04C11DB7;

    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_CMD = 8'h04;
    localparam logic [7:0] REG_TXDATA = 8'h08;
    localparam logic [7:0] REG_STATUS = 8'h0C;
    localparam logic [7:0] REG_RXDATA = 8'h10;
    localparam logic [7:0] REG_TXCRC = 8'h14;
    localparam logic [7:0] REG_RXCRC = 8'h18;

    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_PM_EN_BIT = 1;
    localparam int CTRL_FILL_BIT = 2;
    localparam logic [2:0] CTRL_RESET_VAL = 3'h1;

    localparam int CMD_FRAME_BIT = 0;
    localparam int CMD_PARTIAL_BIT = 1;
    localparam int CMD_SLUMBER_BIT = 2;
    localparam int CMD_ABORT_BIT = 3;
    localparam int CMD_CRC_BIT = 4;
    localparam int CMD_EOF_BIT = 5;

    localparam int STAT_PHY_RDY_BIT = 4;
    localparam int STAT_TX_FULL_BIT = 5;
    localparam int STAT_NOCOMM_BIT = 6;
    localparam int STAT_FRAME_BIT = 7;
    localparam int STAT_RX_CONT_BIT = 8;

    typedef enum logic [3:0] {
        ST_RESET = 4'h0, ST_NOCOMM_ERR = 4'h1, ST_NOCOMM = 4'h2,
        ST_SEND_ALIGN = 4'h3, ST_IDLE = 4'h4, ST_HOST_CHK = 4'h5,
        ST_RCV_WAIT = 4'h6, ST_PM_PARTIAL = 4'h7, ST_PM_SLUMBER = 4'h8,
        ST_PM_OFF = 4'h9, ST_PM_DENY = 4'hA, ST_SEND_SOF = 4'hB,
        ST_SEND_DATA = 4'hC
    } link_state_type;

    typedef enum logic [3:0] {
        P_SYNC = 4'h0, P_ALIGN = 4'h1, P_X_RDY = 4'h2, P_R_RDY = 4'h3,
        P_SOF = 4'h4, P_EOF = 4'h5, P_CONT = 4'h6, P_HOLD = 4'h7,
        P_HOLDA = 4'h8, P_PMREQ_P = 4'h9, P_PMREQ_S = 4'hA, P_WTRM = 4'hB
    } prim_type;

    typedef enum logic [1:0] {
        GAP_HOLD = 2'h0, GAP_CONT = 2'h1, GAP_FILL = 2'h2
    } gap_type;

    function automatic logic [47:0] lfsr_run(input logic [15:0] s);
        logic [15:0] r;
        logic [31:0] w;
        logic fb;
        r = s;
        w = '0;
        for (int i = 0; i < 32; i++) begin
            w[31-i] = r[15];
            fb = r[15] ^ r[14] ^ r[12] ^ r[3];
            r = {r[14:0], fb};
        end
        lfsr_run = {r, w};
    endfunction : lfsr_run

    function automatic logic [31:0] crc_step(input logic [31:0] c,
                                             input logic [31:0] d);
        logic [31:0] r;
        logic fb;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            fb = r[31] ^ d[i];
            r = {r[30:0], 1'b0};
            if (fb) begin
                r = r ^ CRC_POLY;
            end
        end
        crc_step = r;
    endfunction : crc_step
endpackage : link_pkg

// ===== rtl/lfsr_if.sv
`timescale 1ns/1ps
`default_nettype none
interface lfsr_if;
    logic seed;
    logic step;
    logic [31:0] word;
    modport ctrl (output seed, output step, input word);
    modport core (input seed, input step, output word);
endinterface : lfsr_if
`default_nettype wire

// ===== rtl/dword_scrambler.sv
`timescale 1ns/1ps
`default_nettype none
module dword_scrambler
    import link_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    lfsr_if.core lf
);
    logic [15:0] state;
    logic [47:0] run;

    assign run = lfsr_run(state);
    // 32 scrambling bits per dword from the current state
    assign lf.word = run[31:0];

    always_ff @(posedge clk_sys) begin
        if (srst || lf.seed) begin
            state <= SCR_SEED;
        end else if (lf.step) begin
            state <= run[47:32];
        end
    end

    a_seed_loads: assert property (@(posedge clk_sys)
        disable iff (srst) lf.seed |=> state == SCR_SEED)
        else $error("scrambler not at seed after load");

    a_idle_stable: assert property (@(posedge clk_sys)
        disable iff (srst) !lf.seed && !lf.step |=> $stable(state))
        else $error("scrambler moved without a step");

    a_one_step: assert property (@(posedge clk_sys)
        disable iff (srst) lf.step && !lf.seed
        |=> state == $past(run[47:32]))
        else $error("scrambler step is not one dword");
endmodule : dword_scrambler
`default_nettype wire

// ===== rtl/host_link_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// How it works
// - every frame dword between SOF and EOF, CRC included, leaves scrambled
// - dwords are XORed with an x16+x15+x13+x4+1 LFSR
// - payload LFSR seeds to FFFFh at reset and at every SOF sent or received
// - transmit: CRC takes the plain dword, then it is scrambled
// - receive: decoded dword is descrambled, delivered, then fed to CRC
// - a second LFSR, stepped only while filler is sent, supplies filler after CONT
// - primitives, ALIGN too, go unscrambled and never step the LFSR
// - filler after CONT never steps the payload LFSR
// - idle sends SYNC continuously
// - host frame request with phy ready goes to ready check
// - device-side variant; this host end never takes it
// - partial or slumber request with phy ready goes to power state
// - X_RDY received in idle goes to receive wait
// - PMREQ with power modes on goes to power-off acknowledge
// - PMREQ with power modes off goes to power deny
// - otherwise idle stays idle, ignoring errors and unknown dwords
// - phy not ready in idle goes to no-comm error
// - no-comm error is flagged, then no-comm follows
// - no-comm sends ALIGN, waits for phy ready, then send-align
// - send-align sends ALIGN, falls back on not ready, else idle
// - link reset holds the state machine and datapath, drops requests, resets the phy; nocomm_err and the filler LFSR reset on srst only
// - leaving reset the link enters no-comm
// - CRC32 starts at 52325032h for every frame
// - ready check sends X_RDY, waits for R_RDY or X_RDY
module host_link_ctrl
    import link_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic phy_ready,
    input wire logic rx_valid,
    input wire logic rx_is_prim,
    input wire prim_type rx_prim,
    input wire logic [31:0] rx_data,
    output logic [31:0] tx_data,
    output logic tx_is_prim,
    output prim_type tx_prim,
    output logic phy_reset,
    output logic phy_enable
);
    link_state_type state, next_state;
    gap_type gap, next_gap;
    logic [2:0] ctrl;
    logic link_rst;
    logic wr_q;
    logic [7:0] addr_q;
    logic wr_ctrl, wr_cmd, wr_txd, wr_stat;
    logic frame_pend, partial_pend, slumber_pend, abort_pend;
    logic crc_pend, eof_pend, txd_pend;
    logic [31:0] txd;
    logic nocomm_err;
    logic [31:0] tx_crc, rx_crc, rx_word;
    logic rx_in_cont;
    logic [31:0] next_tx_data;
    logic next_tx_is_prim;
    prim_type next_tx_prim;
    logic send_data, send_crc, send_eof;
    logic rx_dword;
    logic [31:0] rx_plain;
    logic [31:0] rd_mux;

    lfsr_if tx_lf ();
    lfsr_if rx_lf ();
    lfsr_if fill_lf ();

    dword_scrambler u_tx_scr (
        .clk_sys(clk_sys),
        .srst(link_rst),
        .lf(tx_lf)
    );
    dword_scrambler u_rx_scr (
        .clk_sys(clk_sys),
        .srst(link_rst),
        .lf(rx_lf)
    );
    dword_scrambler u_fill_scr (
        .clk_sys(clk_sys),
        .srst(srst),
        .lf(fill_lf)
    );

    function automatic logic rx_is(input logic v, input logic p,
                                   input prim_type k, input prim_type want);
        rx_is = v && p && (k == want);
    endfunction : rx_is

    assign link_rst = srst || ctrl[CTRL_RESET_BIT];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign phy_reset = (state == ST_RESET);
    assign phy_enable = (state != ST_RESET);

    // bus slave: address phase latch, write in data phase
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            wr_q <= 1'b0;
            addr_q <= 8'h00;
            hrdata <= 32'h0000_0000;
        end else begin
            wr_q <= hsel && htrans[1] && hready && hwrite;
            if (hsel && htrans[1] && hready) begin
                addr_q <= haddr[7:0];
                hrdata <= hwrite ? 32'h0000_0000 : rd_mux;
            end
        end
    end

    assign wr_ctrl = wr_q && (addr_q == REG_CTRL);
    assign wr_cmd = wr_q && (addr_q == REG_CMD);
    assign wr_txd = wr_q && (addr_q == REG_TXDATA);
    assign wr_stat = wr_q && (addr_q == REG_STATUS);

    always_comb begin
        case (haddr[7:0])
            REG_CTRL: rd_mux = {29'h0, ctrl};
            REG_STATUS: rd_mux = {23'h0, rx_in_cont, frame_pend,
                                  nocomm_err, txd_pend, phy_ready, state};
            REG_RXDATA: rd_mux = rx_word;
            REG_TXCRC: rd_mux = tx_crc;
            REG_RXCRC: rd_mux = rx_crc;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            ctrl <= CTRL_RESET_VAL;
        end else if (wr_ctrl) begin
            ctrl <= hwdata[2:0];
        end
    end

    // pending requests; a new request wins over its consumption
    always_ff @(posedge clk_sys) begin
        if (link_rst) begin
            frame_pend <= 1'b0;
            partial_pend <= 1'b0;
            slumber_pend <= 1'b0;
            abort_pend <= 1'b0;
            crc_pend <= 1'b0;
            eof_pend <= 1'b0;
        end else begin
            if (wr_cmd && hwdata[CMD_FRAME_BIT]) begin
                frame_pend <= 1'b1;
            end else if (next_state == ST_HOST_CHK && state == ST_IDLE) begin
                frame_pend <= 1'b0;
            end
            if (wr_cmd && hwdata[CMD_PARTIAL_BIT]) begin
                partial_pend <= 1'b1;
            end else if (next_state == ST_PM_PARTIAL) begin
                partial_pend <= 1'b0;
            end
            if (wr_cmd && hwdata[CMD_SLUMBER_BIT]) begin
                slumber_pend <= 1'b1;
            end else if (next_state == ST_PM_SLUMBER) begin
                slumber_pend <= 1'b0;
            end
            if (wr_cmd && hwdata[CMD_ABORT_BIT]) begin
                abort_pend <= 1'b1;
            end else if (state == ST_IDLE) begin
                abort_pend <= 1'b0;
            end
            if (wr_cmd && hwdata[CMD_CRC_BIT]) begin
                crc_pend <= 1'b1;
            end else if (send_crc) begin
                crc_pend <= 1'b0;
            end
            if (wr_cmd && hwdata[CMD_EOF_BIT]) begin
                eof_pend <= 1'b1;
            end else if (send_eof) begin
                eof_pend <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (link_rst) begin
            txd_pend <= 1'b0;
            txd <= 32'h0000_0000;
        end else if (wr_txd && !txd_pend) begin
            txd_pend <= 1'b1;
            txd <= hwdata;
        end else if (send_data) begin
            txd_pend <= 1'b0;
        end
    end

    // no-comm error flag, write one to clear, setting wins
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            nocomm_err <= 1'b0;
        end else if (state == ST_NOCOMM_ERR) begin
            nocomm_err <= 1'b1;
        end else if (wr_stat && hwdata[STAT_NOCOMM_BIT]) begin
            nocomm_err <= 1'b0;
        end
    end

    always_comb begin
        next_state = state;
        case (state)
            ST_RESET: next_state = ST_NOCOMM;
            ST_NOCOMM_ERR: next_state = ST_NOCOMM;
            ST_NOCOMM: next_state = phy_ready ? ST_SEND_ALIGN
                                              : ST_NOCOMM;
            ST_SEND_ALIGN: next_state = phy_ready ? ST_IDLE
                                                  : ST_NOCOMM_ERR;
            ST_IDLE: begin
                if (!phy_ready) begin
                    next_state = ST_NOCOMM_ERR;
                end else if (frame_pend) begin
                    next_state = ST_HOST_CHK;
                end else if (partial_pend) begin
                    next_state = ST_PM_PARTIAL;
                end else if (slumber_pend) begin
                    next_state = ST_PM_SLUMBER;
                end else if (rx_is(rx_valid, rx_is_prim, rx_prim,
                                   P_X_RDY)) begin
                    next_state = ST_RCV_WAIT;
                end else if (rx_is(rx_valid, rx_is_prim, rx_prim,
                                   P_PMREQ_P) ||
                             rx_is(rx_valid, rx_is_prim, rx_prim,
                                   P_PMREQ_S)) begin
                    next_state = ctrl[CTRL_PM_EN_BIT] ? ST_PM_OFF
                                                      : ST_PM_DENY;
                end else begin
                    next_state = ST_IDLE;
                end
            end
            ST_HOST_CHK: begin
                if (rx_is(rx_valid, rx_is_prim, rx_prim, P_R_RDY)) begin
                    next_state = ST_SEND_SOF;
                end else if (rx_is(rx_valid, rx_is_prim, rx_prim,
                                   P_X_RDY)) begin
                    next_state = ST_RCV_WAIT;
                end
            end
            ST_SEND_SOF: next_state = ST_SEND_DATA;
            ST_SEND_DATA: next_state = send_eof ? ST_IDLE : ST_SEND_DATA;
            ST_RCV_WAIT, ST_PM_PARTIAL, ST_PM_SLUMBER, ST_PM_OFF,
            ST_PM_DENY: next_state = abort_pend ? ST_IDLE : state;
            default: next_state = ST_RESET;
        endcase
        if (state != ST_RESET && state != ST_NOCOMM &&
            state != ST_NOCOMM_ERR && !phy_ready) begin
            next_state = ST_NOCOMM_ERR;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (link_rst) begin
            state <= ST_RESET;
        end else begin
            state <= next_state;
        end
    end

    // transmit word selection
    assign send_data = (state == ST_SEND_DATA) && txd_pend;
    assign send_crc = (state == ST_SEND_DATA) && !txd_pend && crc_pend;
    assign send_eof = (state == ST_SEND_DATA) && !txd_pend && !crc_pend &&
                      eof_pend;
    assign tx_lf.seed = (state == ST_SEND_SOF);
    assign tx_lf.step = send_data || send_crc;
    assign fill_lf.seed = 1'b0;
    assign fill_lf.step = (state == ST_SEND_DATA) && !txd_pend &&
                          !crc_pend && !eof_pend &&
                          (gap == GAP_FILL);

    always_comb begin
        next_tx_data = 32'h0000_0000;
        next_tx_is_prim = 1'b1;
        next_tx_prim = P_SYNC;
        next_gap = GAP_HOLD;
        case (state)
            ST_RESET, ST_NOCOMM_ERR, ST_NOCOMM,
            ST_SEND_ALIGN: next_tx_prim = P_ALIGN;
            ST_HOST_CHK: next_tx_prim = P_X_RDY;
            ST_SEND_SOF: next_tx_prim = P_SOF;
            ST_SEND_DATA: begin
                next_gap = gap;
                if (send_data) begin
                    next_tx_is_prim = 1'b0;
                    next_tx_data = txd ^ tx_lf.word;
                    next_gap = GAP_HOLD;
                end else if (send_crc) begin
                    next_tx_is_prim = 1'b0;
                    next_tx_data = tx_crc ^ tx_lf.word;
                end else if (send_eof) begin
                    next_tx_prim = P_EOF;
                end else if (gap == GAP_HOLD) begin
                    next_tx_prim = P_HOLD;
                    next_gap = GAP_CONT;
                end else if (gap == GAP_CONT && ctrl[CTRL_FILL_BIT]) begin
                    next_tx_prim = P_CONT;
                    next_gap = GAP_FILL;
                end else if (gap == GAP_FILL) begin
                    next_tx_is_prim = 1'b0;
                    next_tx_data = fill_lf.word;
                end else begin
                    next_tx_prim = P_HOLD;
                end
            end
            default: next_tx_prim = P_SYNC;
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (link_rst) begin
            tx_data <= 32'h0000_0000;
            tx_is_prim <= 1'b1;
            tx_prim <= P_ALIGN;
            gap <= GAP_HOLD;
        end else begin
            tx_data <= next_tx_data;
            tx_is_prim <= next_tx_is_prim;
            tx_prim <= next_tx_prim;
            gap <= next_gap;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (link_rst || state == ST_SEND_SOF) begin
            tx_crc <= CRC_INIT;
        end else if (send_data) begin
            tx_crc <= crc_step(tx_crc, txd);
        end
    end

    // receive path
    assign rx_dword = rx_valid && !rx_is_prim && !rx_in_cont;
    assign rx_plain = rx_data ^ rx_lf.word;
    assign rx_lf.seed = rx_is(rx_valid, rx_is_prim, rx_prim, P_SOF);
    assign rx_lf.step = rx_dword;

    always_ff @(posedge clk_sys) begin
        if (link_rst) begin
            rx_in_cont <= 1'b0;
            rx_word <= 32'h0000_0000;
            rx_crc <= CRC_INIT;
        end else begin
            if (rx_valid && rx_is_prim) begin
                rx_in_cont <= (rx_prim == P_CONT);
            end
            if (rx_lf.seed) begin
                rx_crc <= CRC_INIT;
            end else if (rx_dword) begin
                rx_word <= rx_plain;
                rx_crc <= crc_step(rx_crc, rx_plain);
            end
        end
    end

    a_idle_sync: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE |=> tx_is_prim && tx_prim == P_SYNC)
        else $error("idle did not send SYNC");

    a_frame_req: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE && phy_ready && frame_pend
        |=> state == ST_HOST_CHK ##1 tx_prim == P_X_RDY)
        else $error("frame request not taken to ready check");

    a_xrdy_rcv: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE && phy_ready && !frame_pend && !partial_pend &&
        !slumber_pend && rx_is(rx_valid, rx_is_prim, rx_prim, P_X_RDY)
        |=> state == ST_RCV_WAIT)
        else $error("X_RDY in idle not taken");

    a_pm_ack: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE && phy_ready && !frame_pend && !partial_pend &&
        !slumber_pend && rx_valid && rx_is_prim &&
        rx_prim == P_PMREQ_S && ctrl[CTRL_PM_EN_BIT]
        |=> state == ST_PM_OFF)
        else $error("power request not acknowledged");

    a_pm_deny: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE && phy_ready && !frame_pend && !partial_pend &&
        !slumber_pend && rx_valid && rx_is_prim &&
        rx_prim == P_PMREQ_P && !ctrl[CTRL_PM_EN_BIT]
        |=> state == ST_PM_DENY)
        else $error("power request not denied");

    a_phy_drop: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_IDLE && !phy_ready
        |=> state == ST_NOCOMM_ERR ##1 nocomm_err && state == ST_NOCOMM)
        else $error("phy drop not reported");

    a_rst_hold: assert property (@(posedge clk_sys)
        disable iff (srst)
        link_rst |=> state == ST_RESET && phy_reset && !frame_pend)
        else $error("link reset not holding");

    a_rst_exit: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_RESET |=> state == ST_NOCOMM)
        else $error("reset did not lead to no-comm");

    a_align_seq: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_SEND_ALIGN && phy_ready
        |=> tx_prim == P_ALIGN && state == ST_IDLE)
        else $error("send-align misbehaved");

    a_crc_seed: assert property (@(posedge clk_sys)
        disable iff (link_rst)
        state == ST_SEND_SOF |=> tx_crc == CRC_INIT && tx_prim == P_SOF)
        else $error("CRC not seeded at SOF");
endmodule : host_link_ctrl
`default_nettype wire

// ===== testbench/phy_model.sv
`timescale 1ns/1ps
`default_nettype none
module phy_model
    import link_pkg::*;
(
    input wire logic clk_sys,
    input wire logic ready_in,
    input wire logic send,
    input wire logic dsend,
    input wire logic [31:0] dat,
    input wire prim_type prim,
    output logic phy_ready,
    output logic rx_valid,
    output logic rx_is_prim,
    output prim_type rx_prim,
    output logic [31:0] rx_data
);
    // one dword per clock, sync when nothing asked for
    always_ff @(posedge clk_sys) begin
        phy_ready <= ready_in;
        rx_valid <= 1'b1;
        rx_is_prim <= !dsend;
        rx_prim <= send ? prim : P_SYNC;
        rx_data <= dat;
    end
endmodule : phy_model
`default_nettype wire

// ===== testbench/host_link_ctrl_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module host_link_ctrl_tb_top
    import link_pkg::*;
;
    logic clk_sys = 0, srst = 1, hsel = 0, hwrite = 0, hreadyout, hresp;
    logic [1:0] htrans = 2'b00;
    logic [31:0] haddr = '0, hwdata = '0, hrdata, rx_data, tx_data, q;
    logic phy_ready, rx_valid, rx_is_prim, tx_is_prim, phy_reset, phy_enable;
    logic rdy = 0, send = 0, dsend = 0;
    logic [31:0] dat = 32'h0;
    prim_type pr = P_SYNC, rx_prim, tx_prim;
    int bad_count = 0, n_compared = 0;
    host_link_ctrl i_host_link_ctrl (.clk_sys(clk_sys), .srst(srst),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(3'b010), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .phy_ready(phy_ready), .rx_valid(rx_valid), .rx_is_prim(rx_is_prim),
        .rx_prim(rx_prim), .rx_data(rx_data), .tx_data(tx_data),
        .tx_is_prim(tx_is_prim), .tx_prim(tx_prim), .phy_reset(phy_reset),
        .phy_enable(phy_enable));
    phy_model i_phy_model (.clk_sys(clk_sys), .ready_in(rdy), .send(send),
        .dsend(dsend), .dat(dat),
        .prim(pr), .phy_ready(phy_ready), .rx_valid(rx_valid),
        .rx_is_prim(rx_is_prim), .rx_prim(rx_prim), .rx_data(rx_data));
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic give_verdict();
        if (bad_count == 0 && n_compared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : give_verdict
    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        @(posedge clk_sys);
        hsel <= 1'b1;
        hwrite <= w;
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        q = hrdata;
    endtask : xfer
    task automatic st(input link_state_type s);
        xfer(1'b0, REG_STATUS, 32'h0);
        chk({28'h0, q[3:0]}, {28'h0, s});
    endtask : st
    task automatic wt(input prim_type p);
        @(negedge clk_sys);
        for (int i = 0; i < 20 && !(tx_is_prim === 1'b1 && tx_prim === p);
             i++) @(negedge clk_sys);
        chk({27'h0, tx_is_prim, tx_prim}, {28'h1, p});
    endtask : wt
    function automatic logic [31:0] scr(input int n);
        logic [15:0] r;
        logic [31:0] w;
        r = SCR_SEED;
        w = 32'h0;
        for (int i = 0; i < 32 * n + 32; i++) begin
            w = {w[30:0], r[15]};
            r = {r[14:0], r[15] ^ r[14] ^ r[12] ^ r[3]};
        end
        return w;
    endfunction : scr
    function automatic logic [31:0] crc1(input logic [31:0] d);
        logic [31:0] c;
        c = CRC_INIT;
        for (int i = 31; i >= 0; i--) begin
            c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CRC_POLY : 32'h0);
        end
        return c;
    endfunction : crc1
    task automatic rx1(input logic isp, input prim_type k,
                       input logic [31:0] d);
        send <= isp;
        pr <= k;
        dsend <= !isp;
        dat <= d;
        @(posedge clk_sys);
    endtask : rx1
    task automatic go(input prim_type p, input logic [31:0] c,
                      input link_state_type e);
        send <= (c == 32'h0);
        pr <= p;
        if (c != 32'h0) xfer(1'b1, REG_CMD, c);
        repeat (3) @(posedge clk_sys);
        send <= 1'b0;
        st(e);
        xfer(1'b1, REG_CMD, 32'h8);
        repeat (3) @(posedge clk_sys);
        st(ST_IDLE);
    endtask : go
    initial begin
        repeat (5000) @(posedge clk_sys);
        bad_count++;
        give_verdict();
    end
    initial begin
        repeat (5) @(posedge clk_sys);
        srst <= 1'b0;
        xfer(1'b0, REG_CTRL, 32'h0);
        chk(q, 32'h1);
        st(ST_RESET);
        chk({31'h0, phy_reset}, 32'h1);
        xfer(1'b1, REG_CTRL, 32'h0);
        repeat (3) @(posedge clk_sys);
        st(ST_NOCOMM);
        wt(P_ALIGN);
        chk({30'h0, phy_enable, phy_reset}, 32'h2);
        rdy <= 1'b1;
        repeat (4) @(posedge clk_sys);
        st(ST_IDLE);
        wt(P_SYNC);
        for (int f = 0; f < 2; f++) begin
            xfer(1'b1, REG_CTRL, {29'h0, f[0], 2'b00});
            xfer(1'b1, REG_TXDATA, 32'h12345678);
            xfer(1'b1, REG_CMD, 32'h1);
            wt(P_X_RDY);
            st(ST_HOST_CHK);
            send <= 1'b1;
            pr <= P_R_RDY;
            wt(P_SOF);
            for (int i = 0; i < 20 && tx_is_prim !== 1'b0; i++)
                @(negedge clk_sys);
            chk(tx_data, 32'h12345678 ^ scr(0));
            wt(f ? P_CONT : P_HOLD);
            xfer(1'b1, REG_CMD, 32'h10);
            repeat (2) @(negedge clk_sys);
            chk(tx_data, crc1(32'h12345678) ^ scr(1));
            xfer(1'b1, REG_CMD, 32'h20);
            wt(P_EOF);
            send <= 1'b0;
            repeat (3) @(posedge clk_sys);
            st(ST_IDLE);
            xfer(1'b0, REG_TXCRC, 32'h0);
            chk(q, crc1(32'h12345678));
        end
        rx1(1'b1, P_SOF, 32'h0);
        rx1(1'b0, P_SYNC, 32'h13579BDF ^ scr(0));
        rx1(1'b1, P_CONT, 32'h0);
        rx1(1'b0, P_SYNC, 32'hFFFFFFFF);
        send <= 1'b0;
        dsend <= 1'b0;
        xfer(1'b0, REG_RXDATA, 32'h0);
        chk(q, 32'h13579BDF);
        xfer(1'b0, REG_RXCRC, 32'h0);
        chk(q, crc1(32'h13579BDF));
        go(P_PMREQ_P, 32'h0, ST_PM_DENY);
        go(P_X_RDY, 32'h0, ST_RCV_WAIT);
        go(P_SYNC, 32'h2, ST_PM_PARTIAL);
        go(P_SYNC, 32'h4, ST_PM_SLUMBER);
        xfer(1'b1, REG_CTRL, 32'h2);
        go(P_PMREQ_S, 32'h0, ST_PM_OFF);
        rdy <= 1'b0;
        repeat (4) @(posedge clk_sys);
        st(ST_NOCOMM);
        chk({31'h0, q[6]}, 32'h1);
        xfer(1'b1, REG_STATUS, 32'h40);
        st(ST_NOCOMM);
        chk({31'h0, q[6]}, 32'h0);
        wt(P_ALIGN);
        rdy <= 1'b1;
        repeat (4) @(posedge clk_sys);
        st(ST_IDLE);
        give_verdict();
    end
endmodule : host_link_ctrl_tb_top
`default_nettype wire
